// File: cdx_pkg.sv
// Constants shared by the data-move and add executor.
// Assumes one clock and a memory that returns read data one cycle
// after the strobe cycle.
// Notes on behaviour
// - Data moves never change any flag
// - Register copy, dest from source, 5 states
// - Copy from memory at H:L into register
// - Copy register to memory at H:L
// - Immediate byte into register, 2 cycles, 7 states
// - Immediate byte to H:L memory, 10 states
// - Pair load: byte3 high, byte2 low
// - Direct A load, low byte first, 13 states
// - Direct A store, low byte first, 13 states
// - Direct pair load: L then H, 16 states
// - Direct pair store: L then H, 16 states
// - Indirect A load/store via B:C or D:E, 7 states
// - Swap H with D, L with E
// - Arithmetic updates all five flags
// - Subtract sets carry on borrow
// - Register add into A, 4 states
// - Memory add into A, 7 states
// - Immediate add into A, 7 states
// - Register add with carry, 4 states
// - Memory add with carry, 7 states
// - Immediate add with carry, 7 states
// - Register subtract from A, 4 states
// - Register codes: 7 A, 0-5 B..L
// - Pair codes: B:C, D:E, H:L, stack
// - Half carry is carry from bit 3
// - Parity even sets, zero result sets zero
package cdx_pkg;

  // ****************************************************
  // Register and pair codes
  // ****************************************************
  localparam logic [2:0] REG_B = 3'h0;
  localparam logic [2:0] REG_C = 3'h1;
  localparam logic [2:0] REG_D = 3'h2;
  localparam logic [2:0] REG_E = 3'h3;
  localparam logic [2:0] REG_H = 3'h4;
  localparam logic [2:0] REG_L = 3'h5;
  localparam logic [2:0] REG_M = 3'h6;
  localparam logic [2:0] REG_A = 3'h7;
  localparam logic [1:0] PR_BC = 2'h0;
  localparam logic [1:0] PR_DE = 2'h1;
  localparam logic [1:0] PR_HL = 2'h2;
  localparam logic [1:0] PR_SP = 2'h3;

  // ****************************************************
  // Fixed opcodes
  // ****************************************************
  localparam logic [7:0] OP_STOP     = 8'h76;
  localparam logic [7:0] OP_PAIR_DST = 8'h22;
  localparam logic [7:0] OP_PAIR_DLD = 8'h2a;
  localparam logic [7:0] OP_ACC_DST  = 8'h32;
  localparam logic [7:0] OP_ACC_DLD  = 8'h3a;
  localparam logic [7:0] OP_SUM_IMM  = 8'hc6;
  localparam logic [7:0] OP_SUM_IMMC = 8'hce;
  localparam logic [7:0] OP_SWAP     = 8'heb;

  // ****************************************************
  // Flags, arithmetic selects, reset values
  // ****************************************************
  localparam int FL_CARRY = 0;
  localparam int FL_P     = 1;
  localparam int FL_HALF  = 2;
  localparam int FL_Z  = 3;
  localparam int FL_S  = 4;
  localparam logic [1:0] ALU_ADD = 2'h0;
  localparam logic [1:0] ALU_ADC = 2'h1;
  localparam logic [1:0] ALU_SUB = 2'h2;
  localparam logic [15:0] PC_RST  = 16'h0000;
  localparam logic [15:0] SP_RST  = 16'h0000;
  localparam logic [4:0]  FLG_RST = 5'h00;

  // ****************************************************
  // State counts per instruction
  // ****************************************************
  localparam logic [4:0] T_COPY  = 5'h05;
  localparam logic [4:0] T_ONE   = 5'h07;
  localparam logic [4:0] T_TWO   = 5'h0a;
  localparam logic [4:0] T_DIR   = 5'h0d;
  localparam logic [4:0] T_PDIR  = 5'h10;
  localparam logic [4:0] T_SHORT = 5'h04;

  // ****************************************************
  // Instruction classes and their access patterns
  // ****************************************************
  localparam logic [4:0] C_COPY_RR  = 5'h00;
  localparam logic [4:0] C_COPY_RM  = 5'h01;
  localparam logic [4:0] C_COPY_MR  = 5'h02;
  localparam logic [4:0] C_LDI_R    = 5'h03;
  localparam logic [4:0] C_LDI_M    = 5'h04;
  localparam logic [4:0] C_PAIR_IMM = 5'h05;
  localparam logic [4:0] C_ACC_DLD  = 5'h06;
  localparam logic [4:0] C_ACC_DST  = 5'h07;
  localparam logic [4:0] C_PAIR_DLD = 5'h08;
  localparam logic [4:0] C_PAIR_DST = 5'h09;
  localparam logic [4:0] C_IND_LD   = 5'h0a;
  localparam logic [4:0] C_IND_ST   = 5'h0b;
  localparam logic [4:0] C_SWAP     = 5'h0c;
  localparam logic [4:0] C_ALU_R    = 5'h0d;
  localparam logic [4:0] C_ALU_M    = 5'h0e;
  localparam logic [4:0] C_ALU_I    = 5'h0f;
  localparam logic [4:0] C_BAD      = 5'h10;
  // Access kinds, two bits per machine cycle after the fetch
  localparam logic [1:0] AK_NONE = 2'h0;
  localparam logic [1:0] AK_PC   = 2'h1;
  localparam logic [1:0] AK_RD   = 2'h2;
  localparam logic [1:0] AK_WR   = 2'h3;
  // Entry: state count, then kinds of cycles 4..1
  localparam logic [16:0][12:0] CLS_TAB = {
    {T_SHORT, 8'h00}, {T_ONE, 8'h01}, {T_ONE, 8'h02},
    {T_SHORT, 8'h00}, {T_SHORT, 8'h00}, {T_ONE, 8'h03},
    {T_ONE, 8'h02}, {T_PDIR, 8'hf5}, {T_PDIR, 8'ha5},
    {T_DIR, 8'h35}, {T_DIR, 8'h25}, {T_TWO, 8'h05},
    {T_TWO, 8'h0d}, {T_ONE, 8'h01}, {T_ONE, 8'h03},
    {T_ONE, 8'h02}, {T_COPY, 8'h00}};

  typedef enum logic [2:0] {
    ST_FETCH = 3'b001,
    ST_MEM   = 3'b010,
    ST_HOLD  = 3'b100
  } cdx_st_e;

endpackage

// File: cdx_alu.sv
// Byte adder for add, add with carry and subtract, with flags.
// Pure logic; the caller registers the result.
module cdx_alu (
  input  wire logic [7:0] opa,
  input  wire logic [7:0] opb,
  input  wire logic [1:0] sel,
  input  wire logic       carry_in,
  output logic      [7:0] res,
  output logic      [4:0] flg
);
  logic [7:0] b;
  logic       cin;
  logic [4:0] lo;
  logic [8:0] sum;
  logic       sub;

  always_comb begin
    sub = (sel == cdx_pkg::ALU_SUB);
    // Subtract is A plus inverted operand plus one
    b = sub ? ~opb : opb;
    cin = sub | ((sel == cdx_pkg::ALU_ADC) & carry_in);
    lo = {1'b0, opa[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    sum = {1'b0, opa} + {1'b0, b} + {8'h00, cin};
    res = sum[7:0];
    flg = cdx_pkg::FLG_RST;
    flg[cdx_pkg::FL_CARRY] = sub ? ~sum[8] : sum[8];
    flg[cdx_pkg::FL_HALF] = lo[4];
    flg[cdx_pkg::FL_Z] = (res == 8'h00);
    flg[cdx_pkg::FL_S] = res[7];
    flg[cdx_pkg::FL_P] = ~^res;
  end
endmodule // cdx_alu

// File: cdx_exec.sv
// Fetches and executes data-move and add/subtract instructions.
// Assumes memory samples a strobe and returns read data on the
// following cycle; one state is one clock.
module cdx_exec (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  mem_rdata,
  output logic      [15:0] mem_addr,
  output logic      [7:0]  mem_wdata,
  output logic             mem_rd,
  output logic             mem_wr,
  output logic             instr_done,
  output logic             bad_op,
  output logic      [7:0]  acc_out,
  output logic      [4:0]  flags_out,
  output logic      [15:0] pc_out
);

  // ****************************************************
  // State
  // ****************************************************
  typedef struct packed {
    cdx_pkg::cdx_st_e st;
    logic [1:0]       ph;
    logic [2:0]       m;
    logic [4:0]       tcnt;
    logic [4:0]       cls;
    logic [7:0]       op;
    logic [7:0]       b2;
    logic [7:0]       b3;
    logic [7:0]       dat;
    logic [7:0]       dhi;
    logic [15:0]      pc;
    logic [15:0]      sp;
    logic [7:0][7:0]  rf;
    logic [4:0]       flg;
    logic [15:0]      addr;
    logic [7:0]       wdata;
    logic             rd;
    logic             wr;
    logic             done;
    logic             bad;
  } cdx_state_s;

  cdx_state_s q_r;
  cdx_state_s q_nxt;

  // ****************************************************
  // Decoding
  // ****************************************************
  function automatic logic [4:0] f_cls(input logic [7:0] op);
    logic [2:0] d;
    logic [2:0] s;
    d = op[5:3];
    s = op[2:0];
    f_cls = cdx_pkg::C_BAD;
    if (op[7:6] == 2'h1) begin
      if (op == cdx_pkg::OP_STOP) begin
        f_cls = cdx_pkg::C_BAD;
      end else if (s == cdx_pkg::REG_M) begin
        f_cls = cdx_pkg::C_COPY_RM;
      end else if (d == cdx_pkg::REG_M) begin
        f_cls = cdx_pkg::C_COPY_MR;
      end else begin
        f_cls = cdx_pkg::C_COPY_RR;
      end
    end else if (op[7:6] == 2'h2) begin
      // Subtract from memory is not served here
      if (d[2:1] == 2'h0) begin
        f_cls = (s == cdx_pkg::REG_M) ? cdx_pkg::C_ALU_M
                                      : cdx_pkg::C_ALU_R;
      end else if (d == {1'b0, cdx_pkg::ALU_SUB}
                   && s != cdx_pkg::REG_M) begin
        f_cls = cdx_pkg::C_ALU_R;
      end
    end else if (op == cdx_pkg::OP_SUM_IMM
                 || op == cdx_pkg::OP_SUM_IMMC) begin
      f_cls = cdx_pkg::C_ALU_I;
    end else if (op == cdx_pkg::OP_SWAP) begin
      f_cls = cdx_pkg::C_SWAP;
    end else if (op[7:6] == 2'h0) begin
      if (s == 3'h6) begin
        f_cls = (d == cdx_pkg::REG_M) ? cdx_pkg::C_LDI_M
                                      : cdx_pkg::C_LDI_R;
      end else if (op[3:0] == 4'h1) begin
        f_cls = cdx_pkg::C_PAIR_IMM;
      end else if (op == cdx_pkg::OP_PAIR_DST) begin
        f_cls = cdx_pkg::C_PAIR_DST;
      end else if (op == cdx_pkg::OP_PAIR_DLD) begin
        f_cls = cdx_pkg::C_PAIR_DLD;
      end else if (op == cdx_pkg::OP_ACC_DST) begin
        f_cls = cdx_pkg::C_ACC_DST;
      end else if (op == cdx_pkg::OP_ACC_DLD) begin
        f_cls = cdx_pkg::C_ACC_DLD;
      end else if (op[3:0] == 4'ha) begin
        f_cls = cdx_pkg::C_IND_LD;
      end else if (op[3:0] == 4'h2) begin
        f_cls = cdx_pkg::C_IND_ST;
      end
    end
  endfunction

  // Kind of bus access in machine cycle m after the fetch
  function automatic logic [1:0] f_acc(input logic [4:0] c,
                                       input logic [2:0] m);
    logic [7:0] pat;
    pat = cdx_pkg::CLS_TAB[c][7:0];
    f_acc = cdx_pkg::AK_NONE;
    if (m != 3'h0 && m <= 3'h4) begin
      f_acc = pat[{m[1:0] - 2'h1, 1'b0} +: 2];
    end
  endfunction

  function automatic logic [15:0] f_pair(input cdx_state_s s,
                                         input logic [1:0] p);
    unique case (p)
      cdx_pkg::PR_BC: f_pair = {s.rf[cdx_pkg::REG_B],
                                s.rf[cdx_pkg::REG_C]};
      cdx_pkg::PR_DE: f_pair = {s.rf[cdx_pkg::REG_D],
                                s.rf[cdx_pkg::REG_E]};
      cdx_pkg::PR_HL: f_pair = {s.rf[cdx_pkg::REG_H],
                                s.rf[cdx_pkg::REG_L]};
      cdx_pkg::PR_SP: f_pair = s.sp;
    endcase
  endfunction

  // ****************************************************
  // Operand and address selection
  // ****************************************************
  logic [1:0]  acc_k;
  logic [1:0]  acc_n;
  logic [4:0]  tl;
  logic        commit;
  logic [15:0] daddr;
  logic [7:0]  wsrc;
  logic [7:0]  alu_b;
  logic [7:0]  alu_res;
  logic [4:0]  alu_flg;
  logic        last_pair;

  always_comb begin
    acc_k = f_acc(q_r.cls, q_r.m);
    acc_n = f_acc(q_r.cls, q_r.m + 3'h1);
    tl = cdx_pkg::CLS_TAB[q_r.cls][12:8];
    commit = (q_r.st == cdx_pkg::ST_HOLD)
             && (q_r.tcnt == tl - 5'h01);
    last_pair = (q_r.m == 3'h4);
    unique case (q_r.cls)
      cdx_pkg::C_ACC_DLD, cdx_pkg::C_ACC_DST,
      cdx_pkg::C_PAIR_DLD, cdx_pkg::C_PAIR_DST: begin
        // Low byte first, high byte at address plus one, carrying into the page
        daddr = {q_r.b3, q_r.b2} + {15'h0000, last_pair};
      end
      cdx_pkg::C_IND_LD, cdx_pkg::C_IND_ST: begin
        daddr = f_pair(q_r, q_r.op[5:4]);
      end
      default: begin
        daddr = f_pair(q_r, cdx_pkg::PR_HL);
      end
    endcase
    unique case (q_r.cls)
      cdx_pkg::C_COPY_MR: wsrc = q_r.rf[q_r.op[2:0]];
      cdx_pkg::C_LDI_M: wsrc = q_r.b2;
      cdx_pkg::C_PAIR_DST: begin
        wsrc = last_pair ? q_r.rf[cdx_pkg::REG_H]
                         : q_r.rf[cdx_pkg::REG_L];
      end
      default: wsrc = q_r.rf[cdx_pkg::REG_A];
    endcase
    unique case (q_r.cls)
      cdx_pkg::C_ALU_M: alu_b = q_r.dat;
      cdx_pkg::C_ALU_I: alu_b = q_r.b2;
      default: alu_b = q_r.rf[q_r.op[2:0]];
    endcase
  end

  cdx_alu u_alu (
    .opa      (q_r.rf[cdx_pkg::REG_A]),
    .opb      (alu_b),
    .sel      (q_r.op[4:3]),
    .carry_in (q_r.flg[cdx_pkg::FL_CARRY]),
    .res      (alu_res),
    .flg      (alu_flg)
  );

  // ****************************************************
  // Sequencer
  // ****************************************************
  always_comb begin
    q_nxt = q_r;
    q_nxt.rd = 1'b0;
    q_nxt.wr = 1'b0;
    q_nxt.done = 1'b0;
    q_nxt.bad = 1'b0;
    q_nxt.tcnt = q_r.tcnt + 5'h01;
    unique case (q_r.st)
      cdx_pkg::ST_FETCH: begin
        q_nxt.ph = q_r.ph + 2'h1;
        if (q_r.ph == 2'h0) begin
          q_nxt.rd = 1'b1;
          q_nxt.addr = q_r.pc;
          q_nxt.pc = q_r.pc + 16'h0001;
        end
        if (q_r.ph == 2'h2) begin
          q_nxt.op = mem_rdata;
          q_nxt.cls = f_cls(mem_rdata);
          q_nxt.m = 3'h1;
          q_nxt.ph = 2'h0;
          q_nxt.st = (f_acc(f_cls(mem_rdata), 3'h1)
                      == cdx_pkg::AK_NONE) ? cdx_pkg::ST_HOLD
                                           : cdx_pkg::ST_MEM;
        end
      end
      cdx_pkg::ST_MEM: begin
        q_nxt.ph = q_r.ph + 2'h1;
        if (q_r.ph == 2'h0) begin
          q_nxt.rd = (acc_k != cdx_pkg::AK_WR);
          q_nxt.wr = (acc_k == cdx_pkg::AK_WR);
          q_nxt.addr = daddr;
          q_nxt.wdata = wsrc;
          if (acc_k == cdx_pkg::AK_PC) begin
            q_nxt.addr = q_r.pc;
            q_nxt.pc = q_r.pc + 16'h0001;
          end
        end
        if (q_r.ph == 2'h2) begin
          if (acc_k == cdx_pkg::AK_PC) begin
            if (q_r.m == 3'h1) begin
              q_nxt.b2 = mem_rdata;
            end else begin
              q_nxt.b3 = mem_rdata;
            end
          end
          if (acc_k == cdx_pkg::AK_RD) begin
            if (last_pair) begin
              q_nxt.dhi = mem_rdata;
            end else begin
              q_nxt.dat = mem_rdata;
            end
          end
          q_nxt.m = q_r.m + 3'h1;
          q_nxt.ph = 2'h0;
          q_nxt.st = (acc_n == cdx_pkg::AK_NONE) ? cdx_pkg::ST_HOLD
                                                 : cdx_pkg::ST_MEM;
        end
      end
      cdx_pkg::ST_HOLD: begin
        if (commit) begin
          q_nxt.st = cdx_pkg::ST_FETCH;
          q_nxt.tcnt = 5'h00;
          q_nxt.ph = 2'h0;
          q_nxt.done = 1'b1;
          q_nxt.bad = (q_r.cls == cdx_pkg::C_BAD);
          unique case (q_r.cls)
            cdx_pkg::C_COPY_RR: begin
              q_nxt.rf[q_r.op[5:3]] = q_r.rf[q_r.op[2:0]];
            end
            cdx_pkg::C_COPY_RM: begin
              q_nxt.rf[q_r.op[5:3]] = q_r.dat;
            end
            cdx_pkg::C_LDI_R: begin
              q_nxt.rf[q_r.op[5:3]] = q_r.b2;
            end
            cdx_pkg::C_PAIR_IMM: begin
              if (q_r.op[5:4] == cdx_pkg::PR_SP) begin
                q_nxt.sp = {q_r.b3, q_r.b2};
              end else begin
                q_nxt.rf[{q_r.op[5:4], 1'b0}] = q_r.b3;
                q_nxt.rf[{q_r.op[5:4], 1'b1}] = q_r.b2;
              end
            end
            cdx_pkg::C_ACC_DLD, cdx_pkg::C_IND_LD: begin
              q_nxt.rf[cdx_pkg::REG_A] = q_r.dat;
            end
            cdx_pkg::C_PAIR_DLD: begin
              q_nxt.rf[cdx_pkg::REG_L] = q_r.dat;
              q_nxt.rf[cdx_pkg::REG_H] = q_r.dhi;
            end
            cdx_pkg::C_SWAP: begin
              q_nxt.rf[cdx_pkg::REG_H] = q_r.rf[cdx_pkg::REG_D];
              q_nxt.rf[cdx_pkg::REG_D] = q_r.rf[cdx_pkg::REG_H];
              q_nxt.rf[cdx_pkg::REG_L] = q_r.rf[cdx_pkg::REG_E];
              q_nxt.rf[cdx_pkg::REG_E] = q_r.rf[cdx_pkg::REG_L];
            end
            cdx_pkg::C_ALU_R, cdx_pkg::C_ALU_M, cdx_pkg::C_ALU_I: begin
              q_nxt.rf[cdx_pkg::REG_A] = alu_res;
              q_nxt.flg = alu_flg;
            end
            default: begin
            end
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      q_r <= '0;
      q_r.st <= cdx_pkg::ST_FETCH;
      q_r.pc <= cdx_pkg::PC_RST;
      q_r.sp <= cdx_pkg::SP_RST;
      q_r.flg <= cdx_pkg::FLG_RST;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign mem_addr = q_r.addr;
  assign mem_wdata = q_r.wdata;
  assign mem_rd = q_r.rd;
  assign mem_wr = q_r.wr;
  assign instr_done = q_r.done;
  assign bad_op = q_r.bad;
  assign acc_out = q_r.rf[cdx_pkg::REG_A];
  assign flags_out = q_r.flg;
  assign pc_out = q_r.pc;

  // ****************************************************
  // Checks
  // ****************************************************
  logic [4:0] gap_r;
  logic       alu_cmt;

  assign alu_cmt = commit && (q_r.cls == cdx_pkg::C_ALU_R
                              || q_r.cls == cdx_pkg::C_ALU_M
                              || q_r.cls == cdx_pkg::C_ALU_I);

  always_ff @(posedge clk_sys) begin
    if (sys_rst || q_r.done) begin
      gap_r <= {4'h0, q_r.done};
    end else begin
      gap_r <= gap_r + 5'h01;
    end
  end

  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  sequence s_low_write;
    mem_wr && q_r.cls == cdx_pkg::C_PAIR_DST && q_r.m == 3'h3;
  endsequence

  sequence s_high_write(logic [15:0] a);
    mem_wr && mem_addr == a + 16'h0001
    && mem_wdata == q_r.rf[cdx_pkg::REG_H];
  endsequence

  a_flags_move_hold: assert property (
    !$stable(flags_out) && !$past(sys_rst) |-> $past(alu_cmt))
    else $error("flags changed outside arithmetic");

  a_copy_rr_len: assert property (
    instr_done && q_r.cls == cdx_pkg::C_COPY_RR |-> gap_r == 5'h05)
    else $error("register copy not 5 states");

  a_copy_from_hl: assert property (
    mem_rd && q_r.st == cdx_pkg::ST_MEM
    && q_r.cls == cdx_pkg::C_COPY_RM
    |-> mem_addr == {q_r.rf[cdx_pkg::REG_H], q_r.rf[cdx_pkg::REG_L]})
    else $error("copy read not at H:L");

  a_copy_to_hl: assert property (
    mem_wr && q_r.cls == cdx_pkg::C_COPY_MR
    |-> mem_addr == {q_r.rf[cdx_pkg::REG_H], q_r.rf[cdx_pkg::REG_L]}
        && mem_wdata == q_r.rf[q_r.op[2:0]])
    else $error("copy write wrong");

  a_imm_mem_len: assert property (
    instr_done && q_r.cls == cdx_pkg::C_LDI_M |-> gap_r == 5'h0a)
    else $error("immediate to memory not 10 states");

  a_direct_len: assert property (
    instr_done && (q_r.cls == cdx_pkg::C_ACC_DLD
                   || q_r.cls == cdx_pkg::C_ACC_DST)
    |-> gap_r == 5'h0d)
    else $error("direct A access not 13 states");

  a_pair_store_seq: assert property (
    s_low_write |-> mem_wdata == q_r.rf[cdx_pkg::REG_L]
    ##3 s_high_write($past(mem_addr, 3)))
    else $error("pair store order wrong");

  a_pair_load_len: assert property (
    instr_done && q_r.cls == cdx_pkg::C_PAIR_DLD |-> gap_r == 5'h10)
    else $error("pair load not 16 states");

  a_ind_pair_addr: assert property (
    mem_rd && q_r.st == cdx_pkg::ST_MEM
    && q_r.cls == cdx_pkg::C_IND_LD
    |-> mem_addr == (q_r.op[4] ? {q_r.rf[cdx_pkg::REG_D],
                                  q_r.rf[cdx_pkg::REG_E]}
                               : {q_r.rf[cdx_pkg::REG_B],
                                  q_r.rf[cdx_pkg::REG_C]}))
    else $error("indirect address wrong");

  a_swap_pairs: assert property (
    commit && q_r.cls == cdx_pkg::C_SWAP
    |=> q_r.rf[cdx_pkg::REG_H] == $past(q_r.rf[cdx_pkg::REG_D])
        && q_r.rf[cdx_pkg::REG_E] == $past(q_r.rf[cdx_pkg::REG_L]))
    else $error("swap wrong");

  a_sub_borrow: assert property (
    alu_cmt && q_r.op[4:3] == cdx_pkg::ALU_SUB
    |=> flags_out[cdx_pkg::FL_CARRY]
        == ($past(q_r.rf[cdx_pkg::REG_A]) < $past(alu_b)))
    else $error("borrow flag wrong");

endmodule // cdx_exec

// File: cdx_mem.sv
// Behavioural byte memory on the far side of the executor's bus.
// Assumes strobes last one cycle; read data is valid only in the
// cycle after the read strobe and shows the inverse otherwise.
module cdx_mem (
  input  wire logic        clk_sys,
  input  wire logic [15:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  input  wire logic        mem_rd,
  input  wire logic        mem_wr,
  output logic      [7:0]  mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] mem [0:65535];
  logic [7:0] last  = 8'h00;
  logic       valid = 1'b0;

  // Plain always: the bench preloads the array by hierarchy
  always @(posedge clk_sys) begin
    valid <= mem_rd;
    if (mem_rd) begin
      last <= mem[mem_addr];
    end
    if (mem_wr) begin
      mem[mem_addr] <= mem_wdata;
    end
  end

  // Released bus shows a changing value so a late sample is caught
  assign mem_rdata = valid ? last : ~last;
endmodule // cdx_mem

// File: tb_top.sv
// Self-checking bench for the data-move and add executor.
// Assumes the memory model answers every strobe with no wait.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************
  // Program table: bytes, count, length, A, flags
  // ****************************************************
  typedef struct {
    logic [23:0] code;
    int          n;
    int          len;
    logic [7:0]  acc;
    logic [4:0]  flg;
  } cdx_row_s;
  cdx_row_s rows [24] = '{
    '{24'h3e5a00, 2, 7, 8'h5a, 5'h00},
    '{24'h06a600, 2, 7, 8'h5a, 5'h00},
    '{24'h800000, 1, 4, 8'h00, 5'h0f},
    '{24'hce1000, 2, 7, 8'h11, 5'h02},
    '{24'h210001, 3, 10, 8'h11, 5'h02},
    '{24'h365500, 2, 10, 8'h11, 5'h02},
    '{24'h860000, 1, 7, 8'h66, 5'h02},
    '{24'h8e0000, 1, 7, 8'hbb, 5'h12},
    '{24'h4f0000, 1, 5, 8'hbb, 5'h12},
    '{24'h910000, 1, 4, 8'h00, 5'h0e},
    '{24'h900000, 1, 4, 8'h5a, 5'h03},
    '{24'h880000, 1, 4, 8'h01, 5'h05},
    '{24'h320002, 3, 13, 8'h01, 5'h05},
    '{24'h3a0001, 3, 13, 8'h55, 5'h05},
    '{24'h221002, 3, 16, 8'h55, 5'h05},
    '{24'h2a2001, 3, 16, 8'h55, 5'h05},
    '{24'h7e0000, 1, 7, 8'hc3, 5'h05},
    '{24'h114001, 3, 10, 8'hc3, 5'h05},
    '{24'heb0000, 1, 4, 8'hc3, 5'h05},
    '{24'h770000, 1, 7, 8'hc3, 5'h05},
    '{24'h0a0000, 1, 7, 8'h3c, 5'h05},
    '{24'h120000, 1, 7, 8'h3c, 5'h05},
    '{24'hc6c400, 2, 7, 8'h00, 5'h0f},
    '{24'h760000, 1, 4, 8'h00, 5'h0f}};

  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic [15:0] mem_addr;
  logic [15:0] pc_out;
  logic [7:0]  mem_rdata;
  logic [7:0]  mem_wdata;
  logic [7:0]  acc_out;
  logic [4:0]  flags_out;
  logic        mem_rd;
  logic        mem_wr;
  logic        instr_done;
  logic        bad_op;
  int          failures = 0;
  int          checks = 0;
  int          cnt;
  int          pc;

  always #12.5 clk_sys = ~clk_sys;

  cdx_exec u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .mem_rdata(mem_rdata), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rd(mem_rd), .mem_wr(mem_wr), .instr_done(instr_done),
    .bad_op(bad_op), .acc_out(acc_out), .flags_out(flags_out),
    .pc_out(pc_out));
  cdx_mem u_mem (.clk_sys(clk_sys), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_rdata(mem_rdata));

  // ****************************************************
  // Compare, wait and closing tasks
  // ****************************************************
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_cnt(input int got, input int exp);
    chk_val(16'(got), 16'(exp));
  endtask

  task automatic summarize;
    $display("Counts: checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Samples 1 ns after each edge so register updates have landed
  task automatic wait_done;
    cnt = 0;
    do begin
      @(posedge clk_sys);
      #1;
      cnt++;
    end while (instr_done !== 1'b1 && cnt < 40);
    if (instr_done !== 1'b1) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, cnt, 1);
      summarize();
    end
  endtask

  // ****************************************************
  // Main sequence
  // ****************************************************
  initial begin
    for (int a = 0; a < 65536; a++) u_mem.mem[a] = 8'h00;
    pc = 0;
    foreach (rows[i]) begin
      for (int k = 0; k < rows[i].n; k++) begin
        u_mem.mem[pc] = rows[i].code[23-8*k -: 8];
        pc++;
      end
    end
    u_mem.mem[16'h0120] = 8'h30;
    u_mem.mem[16'h0121] = 8'h01;
    u_mem.mem[16'h0130] = 8'hc3;
    u_mem.mem[16'ha6bb] = 8'h3c;
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    #1;
    chk_val({acc_out, 3'h0, flags_out}, 16'h0000);
    chk_val(pc_out, 16'h0000);
    $display("Test reset done");
    // First length counts from the release edge
    foreach (rows[i]) begin
      wait_done();
      chk_cnt(cnt, rows[i].len);
      chk_val(16'(acc_out), 16'(rows[i].acc));
      chk_val(16'(flags_out), 16'(rows[i].flg));
      chk_val(16'(bad_op), 16'(rows[i].code[23:16] == 8'h76));
      $display("Test %0d done", i);
    end
    chk_val(16'(u_mem.mem[16'h0200]), 16'h0001);
    chk_val(16'(u_mem.mem[16'h0210]), 16'h0000);
    chk_val(16'(u_mem.mem[16'h0211]), 16'h0001);
    chk_val(16'(u_mem.mem[16'h0140]), 16'h00c3);
    chk_val(16'(u_mem.mem[16'h0130]), 16'h003c);
    chk_val(16'(u_mem.mem[16'h0100]), 16'h0055);
    chk_val(pc_out, 16'h0029);
    $display("Test memory done");
    // Reset in mid-instruction, then the program restarts at zero
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    #1;
    chk_val({acc_out, 3'h0, flags_out}, 16'h0000);
    chk_val(pc_out, 16'h0000);
    wait_done();
    chk_cnt(cnt, 7);
    chk_val(16'(acc_out), 16'h005a);
    $display("Test second reset done");
    summarize();
  end
endmodule // tb_top
